//--- gpio_pkg.sv
package gpio_pkg;

  // ==========================================================
  // Port geometry and timing
  // ==========================================================
  localparam int PORT_WIDTH = 8;
  // Active-high drive time after a rising output, in core clocks.
  localparam int HIGH_DRIVE_CLOCKS = 2;
  // Mode 0 shift clock divides the core clock by this figure.
  localparam int SHIFT_CLOCK_DIVIDE = 12;
  localparam int HALF_DIVIDE = SHIFT_CLOCK_DIVIDE / 2;

  // ==========================================================
  // Port 3 bit positions used by the serial port
  // ==========================================================
  localparam int PORT3_BIT0_POS = 0;
  localparam int PORT3_BIT1_POS = 1;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] LATCH_RESET = 8'hFF;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [8:0] SHIFT_RESET = 9'h1FF;

  // ==========================================================
  // Serial modes and transmitter states
  // ==========================================================
  typedef enum logic [1:0] {
    SER_MODE0,
    SER_MODE1,
    SER_MODE2,
    SER_MODE3
  } ser_mode_e;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SHIFT,
    TX_STOP
  } tx_state_e;

  // Shift clock phase count width.
  localparam int DIV_WIDTH = 4;
  localparam logic [3:0] HALF_DIVIDE_LAST = 4'(HALF_DIVIDE - 1);
  localparam logic [3:0] TX_BITS = 4'h8;

endpackage : gpio_pkg

//--- gpio_port_pad_ctrl.sv
// Functional notes
// - Pad driver on while drive select is 0, input buffer while 1.
// - Output 0 driven low; output 1 held by weak pullup.
// - Rising output drives high for two clocks, then releases.
// - Drive select is output line AND its two-clock delayed copy.
// - Input use needs output line at 1; source must beat pullup.
// - Pullup disable turns pullups off; high output floats after drive.
// - Reset leaves every pin input with pullups enabled.
// - Port 3 alternate inputs come straight from pad input, still readable.
// - Port 3 output line is alternate output AND latch; unused alternate is 1.
// - Port 3 bits 0 and 1 float after clock starts until changed; here they start as pulled-up inputs like every other pin.
// - Mode 0: data on bit 0, core clock over 12 on bit 1.
// - Modes 1-3: receive on bit 0, transmit on bit 1, full duplex.
// - Buffer access starts transmit; otherwise alternates stay at 1.
// - Reception only while receive allow is 1.
module gpio_port_pad_ctrl #(
  parameter int WIDTH = gpio_pkg::PORT_WIDTH
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pullup_disable_in,
  input wire logic [WIDTH-1:0] port1_latch_wr_in,
  input wire logic port1_latch_we_in,
  input wire logic [WIDTH-1:0] port3_latch_wr_in,
  input wire logic port3_latch_we_in,
  input wire logic [1:0] serial_mode_in,
  input wire logic receive_allow_in,
  input wire logic serial_buffer_reg_write_in,
  input wire logic [7:0] serial_buffer_reg_data_in,
  input wire logic [WIDTH-1:0] port1_pad_input_line_in,
  input wire logic [WIDTH-1:0] port3_pad_input_line_in,
  output logic [WIDTH-1:0] port1_pad_oe_out,
  output logic [WIDTH-1:0] port1_pad_data_out,
  output logic [WIDTH-1:0] port1_pad_drive_select_out,
  output logic [WIDTH-1:0] port3_pad_oe_out,
  output logic [WIDTH-1:0] port3_pad_data_out,
  output logic [WIDTH-1:0] port3_pad_drive_select_out,
  output logic pullup_on_out,
  output logic [WIDTH-1:0] port1_pin_read_out,
  output logic [WIDTH-1:0] port3_pin_read_out,
  output logic serial_rx_data_out,
  output logic serial_tx_busy_out
);

  // ==========================================================
  // Latches and line assembly
  // ==========================================================
  logic [WIDTH-1:0] port1_special_function_latch;
  logic [WIDTH-1:0] port3_special_function_latch;
  logic [WIDTH-1:0] port3_alt_out;
  logic [WIDTH-1:0] port3_out_line;
  logic [WIDTH-1:0] p1_pullup;
  logic [WIDTH-1:0] p3_pullup;
  logic alt_bit0;
  logic alt_bit1;

  // Latches reset to 1 so every pin comes up as an input, which also
  // leaves port 3 bits 0 and 1 as pulled-up inputs once the clock runs.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      port1_special_function_latch <= gpio_pkg::LATCH_RESET;
      port3_special_function_latch <= gpio_pkg::LATCH_RESET;
    end
    else
    begin
      if (port1_latch_we_in)
      begin
        port1_special_function_latch <= port1_latch_wr_in;
      end
      if (port3_latch_we_in)
      begin
        port3_special_function_latch <= port3_latch_wr_in;
      end
    end
  end

  // Only bits 0 and 1 have alternates here; the rest idle at 1.
  always_comb
  begin
    port3_alt_out = '1;
    port3_alt_out[gpio_pkg::PORT3_BIT0_POS] = alt_bit0;
    port3_alt_out[gpio_pkg::PORT3_BIT1_POS] = alt_bit1;
  end

  assign port3_out_line = port3_alt_out & port3_special_function_latch;

  // ==========================================================
  // Serial alternate functions
  // ==========================================================
  serial_pins u_serial (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .serial_mode_in(serial_mode_in),
    .receive_allow_in(receive_allow_in),
    .buffer_write_in(serial_buffer_reg_write_in),
    .buffer_data_in(serial_buffer_reg_data_in),
    .rx_pin_in(port3_pad_input_line_in[gpio_pkg::PORT3_BIT0_POS]),
    .alt_bit0_out(alt_bit0),
    .alt_bit1_out(alt_bit1),
    .rx_data_out(serial_rx_data_out),
    .tx_busy_out(serial_tx_busy_out)
  );

  // ==========================================================
  // Pads
  // ==========================================================
  // One pad cell per bit on each port; both share the same delay logic.
  generate
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_pads
      pad_bit u_p1 (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .out_line_in(port1_special_function_latch[i]),
        .pullup_disable_in(pullup_disable_in),
        .pad_drive_select_out(port1_pad_drive_select_out[i]),
        .pad_oe_out(port1_pad_oe_out[i]),
        .pad_data_out(port1_pad_data_out[i]),
        .pullup_on_out(p1_pullup[i])
      );
      pad_bit u_p3 (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .out_line_in(port3_out_line[i]),
        .pullup_disable_in(pullup_disable_in),
        .pad_drive_select_out(port3_pad_drive_select_out[i]),
        .pad_oe_out(port3_pad_oe_out[i]),
        .pad_data_out(port3_pad_data_out[i]),
        .pullup_on_out(p3_pullup[i])
      );
    end
  endgenerate

  // Pullup control is common to both ports; bit 0 of port 1 carries it.
  assign pullup_on_out = p1_pullup[0];

  // Software reads the pins as seen at the pad, alternates or not.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      port1_pin_read_out <= '1;
      port3_pin_read_out <= '1;
    end
    else
    begin
      port1_pin_read_out <= port1_pad_input_line_in;
      port3_pin_read_out <= port3_pad_input_line_in;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  AST_P3_AND: assert property (@(posedge clk_in) disable iff (rst_in)
    !port3_special_function_latch[gpio_pkg::PORT3_BIT0_POS] |=>
      port3_pad_oe_out[gpio_pkg::PORT3_BIT0_POS]
      && !port3_pad_data_out[gpio_pkg::PORT3_BIT0_POS])
    else $error("Port 3 latch at 0 did not drive the pin low.");
  AST_PULLUP: assert property (@(posedge clk_in) disable iff (rst_in)
    pullup_disable_in ##1 pullup_disable_in |-> !pullup_on_out)
    else $error("Pullups stayed on while disabled.");
  AST_PULLUP_SHARED: assert property (@(posedge clk_in) disable iff (rst_in)
    p1_pullup == {WIDTH{pullup_on_out}} && p3_pullup == {WIDTH{pullup_on_out}})
    else $error("Pullup control differs between pads.");
  AST_READBACK: assert property (@(posedge clk_in) disable iff (rst_in)
    port3_pin_read_out == $past(port3_pad_input_line_in))
    else $error("Port 3 pin read differs from the pad input.");
  AST_RESET_INPUT: assert property (@(posedge clk_in)
    $fell(rst_in) |-> port1_pad_oe_out == '0 && port3_pad_oe_out == '0 && pullup_on_out)
    else $error("Pins were not inputs with pullups after reset.");
  AST_MODE0_CLOCK: assert property (@(posedge clk_in) disable iff (rst_in)
    serial_mode_in == 2'h0 && serial_tx_busy_out && port3_special_function_latch[1]
      && $fell(alt_bit1) |=> port3_pad_oe_out[1] && !port3_pad_data_out[1])
    else $error("Shift clock missing on port 3 bit 1.");
  COV_P1_OUT: cover property (@(posedge clk_in) disable iff (rst_in)
    $fell(port1_special_function_latch[0]));
  COV_DUPLEX: cover property (@(posedge clk_in) disable iff (rst_in)
    serial_tx_busy_out && receive_allow_in && serial_mode_in != 2'h0);

endmodule : gpio_port_pad_ctrl

//--- gpio_port_pad_ctrl_tb_top.sv
// ==========================================================
// Self-checking bench for the port pad control block.
// ==========================================================
module gpio_port_pad_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed
  {
    logic [3:0] kind;
    logic [31:0] cyc;
    logic [7:0] val;
  } note_s;

  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic pullup_disable = 1'b0;
  logic [7:0] p1_wr = 8'hFF;
  logic p1_we = 1'b0;
  logic [7:0] p3_wr = 8'hFF;
  logic p3_we = 1'b0;
  logic [1:0] serial_mode = 2'h0;
  logic receive_allow = 1'b0;
  logic ser_buf_wr = 1'b0;
  logic [7:0] ser_buf_data = 8'h00;
  logic [7:0] ext1_en = 8'h00;
  logic [7:0] ext3_en = 8'h00;
  logic [7:0] p1_pin, p3_pin, p1_oe, p1_data, p1_sel, p3_oe, p3_data, p3_sel, p1_read, p3_read;
  logic pullup_on, rx_data, tx_busy;
  note_s notes[$];
  int cycle = 0;
  int error_cnt = 0;
  int checks = 0;
  int seed = 26;

  gpio_port_pad_ctrl #(.WIDTH(8)) uut (.clk_in(clk_in), .rst_in(rst_in),
    .pullup_disable_in(pullup_disable), .port1_latch_wr_in(p1_wr), .port1_latch_we_in(p1_we),
    .port3_latch_wr_in(p3_wr), .port3_latch_we_in(p3_we), .serial_mode_in(serial_mode),
    .receive_allow_in(receive_allow), .serial_buffer_reg_write_in(ser_buf_wr),
    .serial_buffer_reg_data_in(ser_buf_data), .port1_pad_input_line_in(p1_pin),
    .port3_pad_input_line_in(p3_pin), .port1_pad_oe_out(p1_oe), .port1_pad_data_out(p1_data),
    .port1_pad_drive_select_out(p1_sel), .port3_pad_oe_out(p3_oe), .port3_pad_data_out(p3_data),
    .port3_pad_drive_select_out(p3_sel), .pullup_on_out(pullup_on), .port1_pin_read_out(p1_read),
    .port3_pin_read_out(p3_read), .serial_rx_data_out(rx_data), .serial_tx_busy_out(tx_busy));

  pin_partner far1 (.clk_in(clk_in), .oe_in(p1_oe), .data_in(p1_data), .pullup_on_in(pullup_on),
    .ext_en_in(ext1_en), .ext_val_in(8'h00), .pin_out(p1_pin));
  pin_partner far3 (.clk_in(clk_in), .oe_in(p3_oe), .data_in(p3_data), .pullup_on_in(pullup_on),
    .ext_en_in(ext3_en), .ext_val_in(8'h00), .pin_out(p3_pin));

  // ==========================================================
  // Clock, cycle count and hang limit
  // ==========================================================
  initial
  begin
    forever #25 clk_in = ~clk_in;
  end

  // The whole run needs about 700 cycles, so 6000 leaves ample margin.
  always @(posedge clk_in)
  begin
    cycle <= cycle + 1;
    if (cycle == 6000)
    begin
      error_cnt++;
      conclude();
    end
  end

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic check_val(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check_val

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #5;
  endtask : step

  // Notes must be pushed in cycle order, since the watcher only looks at the oldest.
  task automatic expect_at(input logic [3:0] kind, input int cyc, input logic [7:0] val);
    notes.push_back({kind, 32'(cyc), val});
  endtask : expect_at

  task automatic drain;
    while (notes.size() != 0) step(1);
  endtask : drain

  function automatic logic [7:0] observe(input logic [3:0] kind);
    case (kind)
      4'h0: return p1_oe;
      4'h1: return p1_data | ~p1_oe;
      4'h2: return p1_sel;
      4'h3: return p3_oe;
      4'h4: return p3_data;
      4'h5: return p3_sel;
      4'h6: return {7'h00, pullup_on};
      4'h7: return p1_read;
      4'h8: return p3_read;
      4'h9: return {7'h00, rx_data};
      4'hA: return {7'h00, tx_busy};
      4'hC: return {7'h00, p3_data[0]};
      default: return {7'h00, p3_sel[1]};
    endcase
  endfunction : observe

  // Outputs are settled at the falling edge, half a period after they launch.
  always @(negedge clk_in)
  begin
    while (notes.size() != 0 && notes[0].cyc == cycle)
    begin
      check_val(observe(notes[0].kind), notes[0].val);
      void'(notes.pop_front());
    end
  end

  task automatic send_frame(input logic [1:0] mode);
    logic [7:0] b;
    int t0;
    int i;
    b = 8'($random(seed));
    serial_mode = mode;
    ser_buf_data = b;
    ser_buf_wr = 1'b1;
    step(1);
    ser_buf_wr = 1'b0;
    for (i = 0; i < 40 && p3_sel[1] !== 1'b0; i++) step(1);
    check_val({7'h00, p3_sel[1]}, 8'h00);
    t0 = cycle;
    // Mode 0 data bits change as the shift clock on bit 1 rises, so each is checked at a fall.
    if (mode == 2'h0)
      for (i = 0; i < 8; i++)
      begin
        if (i > 0 && i < 5)
          expect_at(4'hB, t0 + 12 * i - 1, 8'h01);
        expect_at(4'hC, t0 + 12 * i, 8'(b[i]));
        if (i > 0 && i < 5)
          expect_at(4'hB, t0 + 12 * i, 8'h00);
      end
    else
      for (i = 0; i < 10; i++)
      begin
        expect_at(4'hB, t0 + 6 + 12 * i, (i == 0) ? 8'h00 : (i == 9) ? 8'h01 : 8'(b[i - 1]));
        if (i == 5)
          expect_at(4'hA, t0 + 66, 8'h01);
      end
    step(30);
    // A second byte in mid-frame must be ignored, so no new frame follows.
    ser_buf_data = ~b;
    ser_buf_wr = 1'b1;
    step(1);
    ser_buf_wr = 1'b0;
    expect_at(4'hA, t0 + ((mode == 2'h0) ? 96 : 120) + 24, 8'h00);
    drain();
  endtask : send_frame

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    logic [7:0] v;
    repeat (12) @(posedge clk_in);
    #5;
    rst_in = 1'b0;
    expect_at(4'h0, cycle + 1, 8'h00);
    expect_at(4'h2, cycle + 1, 8'hFF);
    expect_at(4'h3, cycle + 1, 8'h00);
    expect_at(4'h6, cycle + 1, 8'h01);
    drain();
    // Random output patterns, then release to ones to see the short high drive.
    repeat (4)
    begin
      v = 8'($random(seed));
      p1_wr = v;
      p1_we = 1'b1;
      step(1);
      p1_we = 1'b0;
      expect_at(4'h0, cycle + 2, ~v);
      expect_at(4'h1, cycle + 2, v);
      expect_at(4'h2, cycle + 2, v);
      drain();
      p1_wr = 8'hFF;
      p1_we = 1'b1;
      step(1);
      p1_we = 1'b0;
      // The pad sees the new latch one edge after the write, then kicks for two clocks.
      expect_at(4'h0, cycle + 1, ~v);
      expect_at(4'h1, cycle + 1, 8'hFF);
      expect_at(4'h0, cycle + 2, ~v);
      expect_at(4'h2, cycle + 2, v);
      expect_at(4'h0, cycle + 3, 8'h00);
      expect_at(4'h2, cycle + 3, 8'hFF);
      drain();
    end
    // Pins as inputs; the receiver stays deaf while reception is not allowed.
    repeat (3)
    begin
      v = 8'($random(seed));
      ext1_en = ~v;
      ext3_en = ~v;
      step(1);
      expect_at(4'h7, cycle + 2, v);
      expect_at(4'h8, cycle + 2, v);
      expect_at(4'h9, cycle + 2, 8'h01);
      drain();
    end
    ext1_en = 8'h00;
    serial_mode = 2'h1;
    receive_allow = 1'b1;
    ext3_en = 8'h01;
    step(1);
    expect_at(4'h9, cycle + 3, 8'h00);
    drain();
    ext3_en = 8'h00;
    step(1);
    expect_at(4'h9, cycle + 3, 8'h01);
    drain();
    receive_allow = 1'b0;
    pullup_disable = 1'b1;
    step(1);
    expect_at(4'h6, cycle + 2, 8'h00);
    drain();
    pullup_disable = 1'b0;
    step(1);
    expect_at(4'h6, cycle + 2, 8'h01);
    // Latch low on bit 0 while its alternate output idles high.
    p3_wr = 8'hFE;
    p3_we = 1'b1;
    step(1);
    p3_we = 1'b0;
    expect_at(4'h5, cycle + 2, 8'hFE);
    expect_at(4'h3, cycle + 2, 8'h01);
    expect_at(4'h4, cycle + 2, 8'hFE);
    drain();
    p3_wr = 8'hFF;
    p3_we = 1'b1;
    step(1);
    p3_we = 1'b0;
    expect_at(4'h5, cycle + 6, 8'hFF);
    drain();
    for (int m = 0; m < 4; m++)
      send_frame(2'(m));
    conclude();
  end
endmodule : gpio_port_pad_ctrl_tb_top

//--- pad_bit.sv
// ============================================================
// One port pad: output line, delayed copy and drive select.
// ============================================================
module pad_bit #(
  parameter int DELAY = gpio_pkg::HIGH_DRIVE_CLOCKS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic out_line_in,
  input wire logic pullup_disable_in,
  output logic pad_drive_select_out,
  output logic pad_oe_out,
  output logic pad_data_out,
  output logic pullup_on_out
);

  logic [DELAY-1:0] delay_line;
  logic out_line;

  // Register the output line and its delay chain; reset leaves both at 1 so
  // the pin starts in input mode.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      out_line <= 1'b1;
      delay_line <= '1;
    end
    else
    begin
      out_line <= out_line_in;
      delay_line <= {delay_line[DELAY-2:0], out_line_in};
    end
  end

  // Select rises two clocks after the output line rises.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pad_drive_select_out <= 1'b1;
      pad_oe_out <= 1'b0;
      pad_data_out <= 1'b1;
      pullup_on_out <= 1'b1;
    end
    else
    begin
      // The oldest tap is the line two clocks back, so the kick lasts two clocks.
      pad_drive_select_out <= out_line_in & delay_line[DELAY-1];
      // Driver on while select is 0: low for a 0, high during the kick.
      pad_oe_out <= ~(out_line_in & delay_line[DELAY-1]);
      pad_data_out <= out_line_in;
      pullup_on_out <= ~pullup_disable_in;
    end
  end

  AST_KICK_LENGTH: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(out_line) && !$past(out_line, 2) |->
      pad_oe_out && pad_data_out ##1 pad_oe_out ##1 !pad_oe_out || !out_line)
    else $error("High drive after a rising output did not last two clocks.");
  AST_SELECT_AND: assert property (@(posedge clk_in) disable iff (rst_in)
    pad_drive_select_out == (out_line && $past(out_line, 2)))
    else $error("Drive select is not the AND of the line and its delayed copy.");
  AST_OE_INVERSE: assert property (@(posedge clk_in) disable iff (rst_in)
    pad_oe_out == !pad_drive_select_out)
    else $error("Output enable disagrees with the drive select.");
  AST_NO_HIGH_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
    (out_line [*3]) |-> !pad_oe_out)
    else $error("Pad kept actively driving a steady high.");
  COV_KICK: cover property (@(posedge clk_in) disable iff (rst_in) $rose(out_line) ##2 !pad_oe_out);

endmodule : pad_bit

//--- pin_partner.sv
// ==========================================================
// External pin model: resolves one port's eight pins.
// ==========================================================
module pin_partner
(
  input wire logic clk_in,
  input wire logic [7:0] oe_in,
  input wire logic [7:0] data_in,
  input wire logic pullup_on_in,
  input wire logic [7:0] ext_en_in,
  input wire logic [7:0] ext_val_in,
  output logic [7:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] float_pattern;

  // A floating pin has no defined level, so it toggles each cycle instead of holding a value.
  initial float_pattern = 8'h55;
  always @(posedge clk_in) float_pattern <= ~float_pattern;

  // The external source sinks harder than the weak pullup, so its low level wins.
  assign pin_out = (oe_in & data_in) | (~oe_in & ext_en_in & ext_val_in)
    | (~oe_in & ~ext_en_in & {8{pullup_on_in}})
    | (~oe_in & ~ext_en_in & ~{8{pullup_on_in}} & float_pattern);
endmodule : pin_partner

//--- serial_pins.sv
// ============================================================
// Serial port alternate outputs onto port 3 bits 0 and 1.
// ============================================================
module serial_pins (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [1:0] serial_mode_in,
  input wire logic receive_allow_in,
  input wire logic buffer_write_in,
  input wire logic [7:0] buffer_data_in,
  input wire logic rx_pin_in,
  output logic alt_bit0_out,
  output logic alt_bit1_out,
  output logic rx_data_out,
  output logic tx_busy_out
);

  gpio_pkg::tx_state_e state;
  logic [8:0] shifter;
  logic [3:0] bit_count;
  logic [3:0] div_count;
  logic shift_clock;
  logic mode0;

  assign mode0 = (serial_mode_in == 2'(gpio_pkg::SER_MODE0));

  // Core clock divided by twelve; a phase toggles every six clocks.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      div_count <= '0;
      shift_clock <= 1'b1;
    end
    else if (state == gpio_pkg::TX_IDLE)
    begin
      div_count <= '0;
      shift_clock <= 1'b1;
    end
    else if (div_count == gpio_pkg::HALF_DIVIDE_LAST)
    begin
      div_count <= '0;
      shift_clock <= ~shift_clock;
    end
    else
    begin
      div_count <= div_count + 4'h1;
    end
  end

  // Transmitter: idle line is 1 so the pins remain general outputs.
  // Every mode here shifts at the divided clock; baud control is elsewhere.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= gpio_pkg::TX_IDLE;
      shifter <= gpio_pkg::SHIFT_RESET;
      bit_count <= '0;
    end
    else
    begin
      case (state)
        gpio_pkg::TX_IDLE:
        begin
          if (buffer_write_in)
          begin
            shifter <= mode0 ? {1'b1, buffer_data_in} : {buffer_data_in, 1'b0};
            bit_count <= '0;
            state <= gpio_pkg::TX_SHIFT;
          end
        end
        gpio_pkg::TX_SHIFT:
        begin
          if (div_count == gpio_pkg::HALF_DIVIDE_LAST && !shift_clock)
          begin
            shifter <= {1'b1, shifter[8:1]};
            bit_count <= bit_count + 4'h1;
            if (bit_count == gpio_pkg::TX_BITS)
            begin
              state <= gpio_pkg::TX_STOP;
            end
          end
        end
        gpio_pkg::TX_STOP:
        begin
          shifter <= gpio_pkg::SHIFT_RESET;
          state <= gpio_pkg::TX_IDLE;
        end
        default:
        begin
          state <= gpio_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Route alternates: mode 0 puts data on bit 0 and clock on bit 1.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      alt_bit0_out <= 1'b1;
      alt_bit1_out <= 1'b1;
      rx_data_out <= 1'b1;
      tx_busy_out <= 1'b0;
    end
    else
    begin
      alt_bit0_out <= mode0 ? shifter[0] : 1'b1;
      alt_bit1_out <= mode0 ? shift_clock : shifter[0];
      // Receive path only sees the pin while reception is allowed.
      rx_data_out <= receive_allow_in ? rx_pin_in : 1'b1;
      tx_busy_out <= (state != gpio_pkg::TX_IDLE);
    end
  end

  AST_IDLE_HIGH: assert property (@(posedge clk_in) disable iff (rst_in)
    (state == gpio_pkg::TX_IDLE && !buffer_write_in) [*2] |=> alt_bit0_out && alt_bit1_out)
    else $error("Alternate outputs left 1 without a buffer access.");
  AST_RX_BLOCKED: assert property (@(posedge clk_in) disable iff (rst_in)
    !receive_allow_in |=> rx_data_out)
    else $error("Receive path disturbed while reception is off.");
  AST_DIV_PERIOD: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(shift_clock) && state == gpio_pkg::TX_SHIFT |=>
      shift_clock [*5] ##1 !shift_clock)
    else $error("Shift clock half period is not six core clocks.");
  COV_TX: cover property (@(posedge clk_in) disable iff (rst_in)
    buffer_write_in && state == gpio_pkg::TX_IDLE);
  COV_RX: cover property (@(posedge clk_in) disable iff (rst_in)
    receive_allow_in && !rx_pin_in);

endmodule : serial_pins
